// ---- asr_pkg.sv ----
// Constants shared by the serial readout port of the 16-bit converter.
package asr_pkg;

   // =====================================================================
   // Widths and modes
   localparam int CODE_W = 16;
   localparam logic MODE_CS = 1'b1;
   localparam logic MODE_CHAIN = 1'b0;
   localparam logic [3:0] LAST_BIT = 4'hf;
   localparam logic [3:0] FIRST_STEP = 4'hf;

   // =====================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TCONV_MAX_NS = 480;
   localparam int CONV_CYCLES = TCONV_MAX_NS / CLK_PERIOD_NS;
   localparam int STEP_CYCLES = CONV_CYCLES / CODE_W;
   localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

   // =====================================================================
   // Reset values
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [3:0] COUNT_RST = 4'h0;

   // Conversion sequencer states.
   typedef enum logic [0:0] {ST_ACQUIRE, ST_CONVERT} asr_state_t;

endpackage

// ---- asr_pin_sync.sv ----
// Two-stage synchroniser with edge detection for one pin.
module asr_pin_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Pin side
   input wire logic pin_in,
   // Synchronised side
   output logic level,
   output logic level_prev,
   output logic rise,
   output logic fall
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // =====================================================================
   // Synchroniser chain; the first stage feeds only the second.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Level and edges seen after the second stage.
   assign level = sync_reg;
   assign level_prev = prev_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;

endmodule

// ---- asr_readout_port.sv ----
// Conversion sequencer and serial result readout port of the converter.
module asr_readout_port (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Host pins
   input wire logic convert_strobe,
   input wire logic serial_clock,
   input wire logic select_cascade_input,
   // Serial result pin
   output logic serial_result_output,
   output logic serial_result_oe,
   // Sampled analog value as a straight binary code
   input wire logic [15:0] analog_code,
   // Status
   output logic converting,
   output logic powered_down
);

   // Bounds used by the assertions.
   localparam int A_CONV_MAX = 60;

   logic cnv_lvl;
   logic cnv_rise;
   logic sck_fall;
   logic sel_lvl;
   logic sel_prev;
   logic sel_rise;
   asr_pkg::asr_state_t state_reg;
   logic [7:0] div_reg;
   logic [3:0] step_reg;
   logic [15:0] sar_reg;
   logic [15:0] sample_reg;
   logic [15:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic cs_mode_reg;
   logic unread_reg;
   logic read_active_reg;
   logic chain_active_reg;
   logic out_reg;
   logic oe_reg;
   logic busy_reg;
   logic pd_reg;
   logic step_en;
   logic done;
   logic read_start;
   logic read_stop;
   logic shifting;

   // =====================================================================
   // Pin synchronisers
   asr_pin_sync u_cnv_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(convert_strobe),
      .level(cnv_lvl),
      .level_prev(),
      .rise(cnv_rise),
      .fall()
   );

   asr_pin_sync u_sck_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(serial_clock),
      .level(),
      .level_prev(),
      .rise(),
      .fall(sck_fall)
   );

   asr_pin_sync u_sel_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(select_cascade_input),
      .level(sel_lvl),
      .level_prev(sel_prev),
      .rise(sel_rise),
      .fall()
   );

   // The strobe's falling edge is not needed: its low level is read instead.

   // =====================================================================
   // One successive-approximation step: keep the trial bit if it fits.
   function automatic logic [15:0] sar_step(input logic [15:0] sar, input logic [15:0] target,
                                            input logic [3:0] bit_idx);
      logic [15:0] trial;
      trial = sar | (16'h0001 << bit_idx);
      sar_step = (trial <= target) ? trial : sar;
   endfunction

   // =====================================================================
   // Internal step clock, an enable pulse independent of the serial clock.
   assign step_en = (state_reg == asr_pkg::ST_CONVERT) && (div_reg == asr_pkg::STEP_LAST);
   assign done = step_en && (step_reg == 4'h0);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_reg <= asr_pkg::DIV_RST;
      end else if (state_reg != asr_pkg::ST_CONVERT || step_en) begin
         div_reg <= asr_pkg::DIV_RST;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // Conversion sequencer; a strobe edge during a conversion is ignored.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= asr_pkg::ST_ACQUIRE;
      end else begin
         case (state_reg)
            asr_pkg::ST_ACQUIRE: begin
               if (cnv_rise) begin
                  state_reg <= asr_pkg::ST_CONVERT;
               end
            end
            asr_pkg::ST_CONVERT: begin
               if (done) begin
                  state_reg <= asr_pkg::ST_ACQUIRE;
               end
            end
            default: begin
               state_reg <= asr_pkg::ST_ACQUIRE;
            end
         endcase
      end
   end

   // Mode taken from the select level one cycle before the strobe edge.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cs_mode_reg <= asr_pkg::MODE_CHAIN;
      end else if (cnv_rise && state_reg == asr_pkg::ST_ACQUIRE) begin
         cs_mode_reg <= sel_prev ? asr_pkg::MODE_CS : asr_pkg::MODE_CHAIN;
      end
   end

   // Sample capture and bitwise approximation, most significant first.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sample_reg <= asr_pkg::RESULT_RST;
         sar_reg <= asr_pkg::RESULT_RST;
         step_reg <= asr_pkg::FIRST_STEP;
      end else if (cnv_rise && state_reg == asr_pkg::ST_ACQUIRE) begin
         sample_reg <= analog_code;
         sar_reg <= asr_pkg::RESULT_RST;
         step_reg <= asr_pkg::FIRST_STEP;
      end else if (step_en) begin
         sar_reg <= sar_step(sar_reg, sample_reg, step_reg);
         step_reg <= step_reg - 4'h1;
      end
   end

   // Status flags: busy while converting, powered down otherwise.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_reg <= 1'b0;
         pd_reg <= 1'b1;
      end else if (cnv_rise && state_reg == asr_pkg::ST_ACQUIRE) begin
         busy_reg <= 1'b1;
         pd_reg <= 1'b0;
      end else if (done) begin
         busy_reg <= 1'b0;
         pd_reg <= 1'b1;
      end
   end

   // =====================================================================
   // Readout control. Select-readout starts once the result is ready and
   // either the strobe (3-wire) or the select (4-wire) is low.
   assign read_start = unread_reg && cs_mode_reg && !read_active_reg && !cnv_rise
                       && (!cnv_lvl || !sel_lvl);
   assign read_stop = read_active_reg
                      && (cnv_rise || sel_rise || (sck_fall && bit_cnt_reg == asr_pkg::LAST_BIT));
   assign shifting = sck_fall && (read_active_reg || chain_active_reg) && !cnv_rise;

   // Result waiting flag; a finishing conversion wins over a read start.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         unread_reg <= 1'b0;
      end else if (done) begin
         unread_reg <= 1'b1;
      end else if (read_start || cnv_rise) begin
         unread_reg <= 1'b0;
      end
   end

   // Select-readout activity and falling-edge bit count.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         read_active_reg <= 1'b0;
         bit_cnt_reg <= asr_pkg::COUNT_RST;
      end else if (read_stop) begin
         read_active_reg <= 1'b0;
      end else if (read_start) begin
         read_active_reg <= 1'b1;
         bit_cnt_reg <= asr_pkg::COUNT_RST;
      end else if (shifting && read_active_reg) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // Chain readout lasts from conversion end until the strobe drops.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         chain_active_reg <= 1'b0;
      end else if (done && cs_mode_reg == asr_pkg::MODE_CHAIN) begin
         chain_active_reg <= 1'b1;
      end else if (cnv_rise || !cnv_lvl) begin
         chain_active_reg <= 1'b0;
      end
   end

   // Output shift register; chain mode pulls the select pin into the bottom.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shift_reg <= asr_pkg::RESULT_RST;
      end else if (done) begin
         shift_reg <= sar_step(sar_reg, sample_reg, step_reg);
      end else if (shifting) begin
         shift_reg <= {shift_reg[14:0], chain_active_reg ? sel_lvl : 1'b0};
      end
   end

   // Serial pin drive; the top bit is set at read start or chain conversion end, the next bits at falling clock edges.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (cnv_rise) begin
         oe_reg <= 1'b0;
      end else if (done && cs_mode_reg == asr_pkg::MODE_CHAIN) begin
         out_reg <= sar_step(sar_reg, sample_reg, step_reg) >> 15 != 16'h0000;
         oe_reg <= 1'b1;
      end else if (read_start) begin
         out_reg <= shift_reg[15];
         oe_reg <= 1'b1;
      end else if (read_stop) begin
         oe_reg <= 1'b0;
      end else if (shifting) begin
         out_reg <= shift_reg[14];
      end else if (!busy_reg && !read_active_reg && !chain_active_reg && !unread_reg && !cnv_lvl && !sel_lvl) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b1;
      end else if (!busy_reg && !read_active_reg && !chain_active_reg && (cnv_lvl || sel_lvl)
                   && !read_start) begin
         oe_reg <= 1'b0;
      end
   end

   assign serial_result_output = out_reg;
   assign serial_result_oe = oe_reg;
   assign converting = busy_reg;
   assign powered_down = pd_reg;

   // =====================================================================
   // Assertions
   property p_mode_chain;
      @(posedge core_clk) disable iff (srst)
      (cnv_rise && state_reg == asr_pkg::ST_ACQUIRE && !sel_prev) |=> (cs_mode_reg == asr_pkg::MODE_CHAIN);
   endproperty
   a_mode_chain: assert property (p_mode_chain) else $error("Tied select did not give chain mode.");

   property p_mode_cs;
      @(posedge core_clk) disable iff (srst)
      (cnv_rise && state_reg == asr_pkg::ST_ACQUIRE && sel_prev) |=> cs_mode_reg && busy_reg;
   endproperty
   a_mode_cs: assert property (p_mode_cs) else $error("High select did not give select-readout mode.");

   property p_float_on_start;
      @(posedge core_clk) disable iff (srst)
      cnv_rise |=> !oe_reg;
   endproperty
   a_float_on_start: assert property (p_float_on_start) else $error("Output driven after strobe rise.");

   property p_conv_ends;
      @(posedge core_clk) disable iff (srst)
      $rose(busy_reg) |-> ##[1:A_CONV_MAX] (!busy_reg && pd_reg);
   endproperty
   a_conv_ends: assert property (p_conv_ends) else $error("Conversion did not end and power down.");

   property p_msb_first;
      @(posedge core_clk) disable iff (srst)
      read_start |=> (oe_reg && out_reg == $past(shift_reg[15]));
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("First bit is not the top result bit.");

   property p_next_bit;
      @(posedge core_clk) disable iff (srst)
      (shifting && read_active_reg && !read_stop) |=> (out_reg == $past(shift_reg[14]));
   endproperty
   a_next_bit: assert property (p_next_bit) else $error("Wrong bit after a falling clock edge.");

   property p_float_16th;
      @(posedge core_clk) disable iff (srst)
      (read_active_reg && sck_fall && bit_cnt_reg == asr_pkg::LAST_BIT) |=> !oe_reg ##1 !read_active_reg;
   endproperty
   a_float_16th: assert property (p_float_16th) else $error("Output still driven after 16th edge.");

   property p_result_code;
      @(posedge core_clk) disable iff (srst)
      done |=> (shift_reg == $past(sample_reg));
   endproperty
   a_result_code: assert property (p_result_code) else $error("Result differs from sampled code.");

   property p_sck_no_part;
      @(posedge core_clk) disable iff (srst)
      (busy_reg && !done) |=> $stable(shift_reg);
   endproperty
   a_sck_no_part: assert property (p_sck_no_part) else $error("Shift register moved during conversion.");

   property p_chain_in;
      @(posedge core_clk) disable iff (srst)
      (shifting && chain_active_reg) |=> (shift_reg[0] == $past(sel_lvl));
   endproperty
   a_chain_in: assert property (p_chain_in) else $error("Chain input not shifted in.");

   property p_hold_result;
      @(posedge core_clk) disable iff (srst)
      (!busy_reg && !sck_fall && !done) |=> $stable(shift_reg);
   endproperty
   a_hold_result: assert property (p_hold_result) else $error("Result changed without a clock edge.");

   property p_bit_steady;
      @(posedge core_clk) disable iff (srst)
      (read_active_reg && !sck_fall && !read_stop && !read_start) |=> $stable(out_reg);
   endproperty
   a_bit_steady: assert property (p_bit_steady) else $error("Output bit changed between falling edges.");

endmodule

// ---- asr_host_model.sv ----
// Host model that drives the strobe, serial clock and select pins and shifts in the result.
module asr_host_model (
   // Clock
   input wire logic core_clk,
   // Host pins
   output logic convert_strobe,
   output logic serial_clock,
   output logic select_cascade_input,
   // Resolved data pin
   input wire logic sdo_wire,
   // Bits that changed between the two serial clock edges
   output int unstable
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Pin setup
   // The serial clock stands low outside frames, as the host keeps it.
   initial begin
      convert_strobe = 1'b0;
      serial_clock = 1'b0;
      select_cascade_input = 1'b1;
      unstable = 0;
   end

   // Waits a number of core clock falling edges.
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // ==========================================================
   // Host sequences
   // Starts a conversion; with tied set, select follows the strobe in the same step.
   task automatic start(input logic sel, input logic tied);
      convert_strobe = 1'b0;
      select_cascade_input = tied ? 1'b0 : sel;
      idle(3);
      convert_strobe = 1'b1;
      if (tied) select_cascade_input = 1'b1;
   endtask

   // Opens a readout (0 strobe low, 1 select low, 2 chain) and takes n bits.
   // Each bit is taken while the clock is low and must still stand before the fall.
   task automatic read(input int n, input int mode, input logic [15:0] cas, output logic [31:0] word);
      word = 32'h0000_0000;
      if (mode == 0) convert_strobe = 1'b0;
      if (mode == 1) select_cascade_input = 1'b0;
      idle(4);
      for (int i = 0; i < n; i++) begin
         word = {word[30:0], sdo_wire};
         serial_clock = 1'b1;
         idle(4);
         if (sdo_wire !== word[0]) unstable++;
         if (mode == 2 && i < 16) select_cascade_input = cas[15 - i];
         serial_clock = 1'b0;
         idle(4);
      end
      if (mode == 1) select_cascade_input = 1'b1;
   endtask
endmodule

// ---- asr_readout_port_test.sv ----
// Self-checking bench for the converter readout port in all three readout forms.
module asr_readout_port_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic core_clk;
   logic srst;
   logic [15:0] analog_code;
   wire convert_strobe;
   wire serial_clock;
   wire select_cascade_input;
   wire sdo_wire;
   logic serial_result_output;
   logic serial_result_oe;
   logic converting;
   logic powered_down;
   int num_errors;
   int checked;
   int unstable;
   logic [15:0] exp_q[$];
   logic [15:0] codes[5];
   logic [31:0] word;

   // The data pin floats whenever the port does not drive it.
   assign sdo_wire = serial_result_oe ? serial_result_output : 1'bz;

   // Clock of 10 ns period.
   always #5 core_clk = ~core_clk;

   // ==========================================================
   // Instances
   asr_readout_port i_dut (
      .core_clk(core_clk),
      .srst(srst),
      .convert_strobe(convert_strobe),
      .serial_clock(serial_clock),
      .select_cascade_input(select_cascade_input),
      .serial_result_output(serial_result_output),
      .serial_result_oe(serial_result_oe),
      .analog_code(analog_code),
      .converting(converting),
      .powered_down(powered_down)
   );

   asr_host_model i_host (
      .core_clk(core_clk),
      .convert_strobe(convert_strobe),
      .serial_clock(serial_clock),
      .select_cascade_input(select_cascade_input),
      .sdo_wire(sdo_wire),
      .unstable(unstable)
   );

   // ==========================================================
   // Tasks
   // Compares one value and counts it.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Runs one conversion and checks status; the input then moves on to show the result is held.
   task automatic convert(input logic [15:0] code, input logic sel, input logic tied);
      analog_code = code;
      exp_q.push_back(code);
      i_host.start(sel, tied);
      repeat (10) @(negedge core_clk);
      check({30'h0, converting, powered_down}, 32'h2);
      if (sel && !tied) check({31'h0, serial_result_oe}, 32'h0);
      repeat (50) @(negedge core_clk);
      check({30'h0, converting, powered_down}, 32'h1);
      analog_code = 16'($urandom);
   endtask

   // Reads n bits and compares them with the model's oldest result.
   task automatic readout(input int n, input int mode, input logic [15:0] cas);
      logic [15:0] code;
      code = exp_q.pop_front();
      i_host.read(n, mode, cas, word);
      check(word, n == 32 ? {code, cas} : 32'(code >> (16 - n)));
      repeat (4) @(negedge core_clk);
      // A 3-wire read cut short keeps driving until the strobe rises again.
      if (mode != 2) check({31'h0, serial_result_oe}, (mode == 0 && n < 16) ? 32'h1 : 32'h0);
   endtask

   // ==========================================================
   // Watchdog: the tests need about 2,600 cycles.
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      analog_code = 16'h0000;
      num_errors = 0;
      checked = 0;
      void'($urandom(32'hc6b0));
      codes = '{16'h0000, 16'h8000, 16'hffff, 16'h0001, 16'h7fff};
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      repeat (3) @(negedge core_clk);
      check({29'h0, serial_result_oe, converting, powered_down}, 32'h1);
      // Three-wire reads of the boundary codes and a random one.
      foreach (codes[i]) begin
         convert(codes[i], 1'b1, 1'b0);
         readout(16, 0, 16'h0000);
      end
      convert(16'($urandom), 1'b1, 1'b0);
      repeat (100) @(negedge core_clk);
      readout(16, 0, 16'h0000);
      $display("test three_wire done");
      // A strobe rise in mid-read floats the pin and starts the next conversion.
      convert(16'($urandom), 1'b1, 1'b0);
      readout(8, 0, 16'h0000);
      convert(16'($urandom), 1'b1, 1'b0);
      readout(16, 0, 16'h0000);
      $display("test strobe_abort done");
      // Four-wire reads, a full one and one cut short by select.
      convert(16'($urandom), 1'b1, 1'b0);
      readout(16, 1, 16'h0000);
      convert(16'($urandom), 1'b1, 1'b0);
      readout(8, 1, 16'h0000);
      $display("test four_wire done");
      // Chain mode, once with select tied to the strobe and once held low.
      convert(16'($urandom), 1'b0, 1'b1);
      check({31'h0, serial_result_oe}, 32'h1);
      readout(32, 2, 16'($urandom));
      convert(16'($urandom), 1'b0, 1'b0);
      readout(32, 2, 16'($urandom));
      $display("test chain done");
      check(32'(unstable), 32'h0);
      stop_test();
   end
endmodule
